// *** pkg/ssc_pkg.sv ***
// Shared constants of the strap, status and control port.
// Assumes one 125 MHz clock; all users write ssc_pkg::name.
package ssc_pkg;
	// Serial control bus addressing
	localparam logic [6:0] I2C_DEV_ADDR = 7'h1D;
	localparam logic [7:0] SUB_DATA_WR = 8'h68;
	localparam logic [7:0] SUB_DATA_RD = 8'h69;
	localparam logic [7:0] SUB_CTRL = 8'h6A;
	// Control word fields
	localparam int CTRL_RESET_BIT = 8;
	localparam int CTRL_TASK_LSB = 0;
	// Command words seen on the data register
	localparam logic [3:0] CMD_READ_CID = 4'h3;
	localparam logic [3:0] CMD_WRITE_REG = 4'h9;
	localparam logic [15:0] RUN_CFG_ADDR = 16'h0FCD;
	// Boot configuration: bit n holds strap line n
	localparam logic [15:0] CFG_MASK = 16'h011F;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam int STRAP_PLL = 0;
	localparam int STRAP_W16 = 1;
	localparam int STRAP_L2 = 2;
	localparam int STRAP_L3 = 3;
	localparam int STRAP_CLK = 4;
	localparam int STRAP_CLOCK_OUTPUT = 8;
	// Status line positions on the parallel port
	localparam logic [19:0] PORT_USED_MASK = 20'hF_F11F;
	localparam int LN_DEEMPH = 0;
	localparam int LN_SRATE = 2;
	localparam int LN_SYNC = 4;
	localparam int LN_CRC = 8;
	localparam int LN_LAYER = 12;
	localparam int LN_IDX = 17;
	localparam int LN_DEMAND = 19;
	// Layer identifiers
	localparam logic [1:0] LAYER_1 = 2'h3;
	localparam logic [1:0] LAYER_2 = 2'h2;
	localparam logic [1:0] LAYER_3 = 2'h1;
	// Serial audio framing
	localparam int AUD_BITS = 20;
	localparam int AUD_SLOT_32 = 32;
	localparam int AUD_VALID_32 = 20;
	localparam int AUD_VALID_16 = 16;
	localparam int AUD_HALF_DIV = 4;
endpackage : ssc_pkg

// *** pkg/ssc_i2c_if.sv ***
// Word-level link between the serial control slave and the port core.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface ssc_i2c_if;
	logic        wr_stb;
	logic        ctrl_stb;
	logic [15:0] wr_word;
	logic [15:0] rd_word;
	logic        busy;
	modport slave (output wr_stb, ctrl_stb, wr_word, input rd_word, busy);
	modport core (input wr_stb, ctrl_stb, wr_word, output rd_word, busy);
endinterface : ssc_i2c_if

// *** verilog/ssc_i2c_slave.sv ***
// Serial control bus slave with one subaddress byte and 16-bit words.
// Assumes bus pins already synchronous to the clock.
`timescale 1ns/100ps
module ssc_i2c_slave (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Bus pins
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_oe,
	output logic      sda_oe,
	// Word side
	ssc_i2c_if.slave  bus
);
	typedef enum {S_IDLE, S_ADDR, S_ACKA, S_SUB, S_ACKS, S_WDAT, S_ACKW,
		S_RDAT, S_RACK} ssc_i2c_st_t;
	ssc_i2c_st_t st_q;
	logic       scl_q, sda_q, rw_q, lo_q, nack_q;
	logic [3:0] bitc_q;
	logic [7:0] sh_q, sub_q, hi_q, rdlo_q;
	logic       start, stop, rise, fall;

	// Bus conditions from the previous pin levels
	assign start = scl_i & scl_q & sda_q & ~sda_i;
	assign stop = scl_i & scl_q & ~sda_q & sda_i;
	assign rise = scl_i & ~scl_q;
	assign fall = ~scl_i & scl_q;

	// Previous pin levels
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Hold the clock low while the core cannot take a word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			scl_oe <= 1'b0;
		else
			scl_oe <= bus.busy && (scl_oe || (!scl_i &&
				(st_q == S_ACKA || st_q == S_ACKW)));
	end

	// Byte sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			bitc_q <= 4'h0;
			sh_q <= 8'h00;
			sub_q <= 8'h00;
			hi_q <= 8'h00;
			rdlo_q <= 8'h00;
			rw_q <= 1'b0;
			lo_q <= 1'b0;
			nack_q <= 1'b0;
			sda_oe <= 1'b0;
			bus.wr_stb <= 1'b0;
			bus.ctrl_stb <= 1'b0;
			bus.wr_word <= 16'h0000;
		end else begin
			bus.wr_stb <= 1'b0;
			bus.ctrl_stb <= 1'b0;
			if (start) begin
				st_q <= S_ADDR;
				bitc_q <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop) begin
				st_q <= S_IDLE;
				sda_oe <= 1'b0;
			end else if (rise) begin
				if (st_q == S_ADDR || st_q == S_SUB || st_q == S_WDAT) begin
					sh_q <= {sh_q[6:0], sda_i};
					bitc_q <= bitc_q + 4'd1;
				end
				if (st_q == S_RACK)
					nack_q <= sda_i;
			end else if (fall) begin
				unique case (st_q)
					S_IDLE: ;
					S_ADDR: if (bitc_q == 4'd8) begin
						if (sh_q[7:1] == ssc_pkg::I2C_DEV_ADDR) begin
							st_q <= S_ACKA;
							sda_oe <= 1'b1;
							rw_q <= sh_q[0];
						end else
							st_q <= S_IDLE;
					end
					S_ACKA: if (rw_q) begin
						// Word is taken whole so both bytes belong together
						sh_q <= (sub_q == ssc_pkg::SUB_DATA_RD) ?
							bus.rd_word[15:8] : 8'h00;
						rdlo_q <= (sub_q == ssc_pkg::SUB_DATA_RD) ?
							bus.rd_word[7:0] : 8'h00;
						sda_oe <= !((sub_q == ssc_pkg::SUB_DATA_RD) &&
							bus.rd_word[15]);
						bitc_q <= 4'd1;
						lo_q <= 1'b0;
						st_q <= S_RDAT;
					end else begin
						sda_oe <= 1'b0;
						bitc_q <= 4'h0;
						st_q <= S_SUB;
					end
					S_SUB: if (bitc_q == 4'd8) begin
						if (sh_q == ssc_pkg::SUB_DATA_WR || sh_q ==
							ssc_pkg::SUB_DATA_RD || sh_q == ssc_pkg::SUB_CTRL) begin
							sub_q <= sh_q;
							sda_oe <= 1'b1;
							st_q <= S_ACKS;
						end else
							st_q <= S_IDLE;
					end
					S_ACKS: begin
						sda_oe <= 1'b0;
						bitc_q <= 4'h0;
						lo_q <= 1'b0;
						st_q <= S_WDAT;
					end
					S_WDAT: if (bitc_q == 4'd8) begin
						sda_oe <= 1'b1;
						st_q <= S_ACKW;
						if (lo_q) begin
							bus.wr_word <= {hi_q, sh_q};
							bus.wr_stb <= (sub_q == ssc_pkg::SUB_DATA_WR);
							bus.ctrl_stb <= (sub_q == ssc_pkg::SUB_CTRL);
						end else
							hi_q <= sh_q;
					end
					S_ACKW: begin
						sda_oe <= 1'b0;
						bitc_q <= 4'h0;
						lo_q <= !lo_q;
						st_q <= S_WDAT;
					end
					S_RDAT: if (bitc_q == 4'd8) begin
						sda_oe <= 1'b0;
						st_q <= S_RACK;
					end else begin
						sda_oe <= !sh_q[6];
						sh_q <= {sh_q[6:0], 1'b0};
						bitc_q <= bitc_q + 4'd1;
					end
					S_RACK: if (!nack_q && !lo_q) begin
						sh_q <= rdlo_q;
						sda_oe <= !rdlo_q[7];
						bitc_q <= 4'd1;
						lo_q <= 1'b1;
						st_q <= S_RDAT;
					end else
						st_q <= S_IDLE;
				endcase
			end
		end
	end

	// Address and subaddress recognition
	a_addr_ack: assert property (
		@(posedge clk) disable iff (!rst_n)
		(fall && !start && !stop && st_q == S_ADDR && bitc_q == 4'd8 &&
		sh_q[7:1] == 7'h1D) |=> sda_oe && st_q == S_ACKA)
		else $error("address not acknowledged");
	a_sub_only: assert property (
		@(posedge clk) disable iff (!rst_n)
		bus.wr_stb |-> sub_q == 8'h68)
		else $error("data strobe on wrong subaddress");
endmodule : ssc_i2c_slave

// *** verilog/ssc_port.sv ***
// Strap sampling, status port, serial audio out and control front end.
// Assumes synchronous pin inputs and decoder status on plain ports.
`timescale 1ns/100ps
// How it works
// - 32-bit slots carry 20 audio bits then 12 zero bits.
// - Audio out selectable 16/32 bit, strobe inversion, data delay.
// - Strap levels latched into boot configuration right after reset.
// - After sampling, strap lines become driven outputs.
// - Loaded configuration lasts until reset; reset reloads straps.
// - Strap meaning: clock, layer enables, 32-bit out, PLL, fixed clock.
// - Line 19 shows data demand.
// - Lines 18:17 show version index, 13:12 show layer.
// - Layer 1 streams are never decoded.
// - Line 8 shows checksum error.
// - Lines 3:2 show sample-rate family, 1:0 show de-emphasis.
// - Frame flag set when header decoding completes.
// - Frame flag cleared when the read command is recognised.
// - Serial control slave with 16-bit words, one subaddress level.
// - Slave answers $3a for write and $3b for read.
// - Slave may stretch the bus clock.
// - Each 16-bit register access is two bytes.
// - Exactly three subaddresses are decoded.
// - $68 data write, $69 data read, $6A control.
// - Data words travel most significant bit first.
module ssc_port #(
	parameter int BCLK_DIV = ssc_pkg::AUD_HALF_DIV
) (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	// Parallel strap and status port
	input  wire logic [19:0] PORT_I,
	output logic      [19:0] PORT_O,
	output logic      [19:0] PORT_OE,
	input  wire logic        PORT_REQUEST_LINE,
	input  wire logic        PORT_SELECT_LINE,
	// Serial control bus
	input  wire logic        SCL_I,
	output logic             SCL_O,
	output logic             SCL_OE,
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE,
	// Decoder status
	input  wire logic        DEC_DEMAND,
	input  wire logic [1:0]  DEC_MPEG_IDX,
	input  wire logic [1:0]  DEC_LAYER,
	input  wire logic        DEC_CRC_ERR,
	input  wire logic        DEC_HDR_DONE,
	input  wire logic [1:0]  DEC_SRATE,
	input  wire logic [1:0]  DEC_DEEMPH,
	// Active configuration
	output logic             CFG_CLK_HI,
	output logic             CFG_LAYER3_EN,
	output logic             CFG_LAYER2_EN,
	output logic             CFG_OUT_32,
	output logic             CFG_PLL_ON,
	output logic             CFG_CLOCK_OUTPUT_FIXED,
	output logic             DECODE_EN,
	output logic [3:0]       TASK_SEL,
	output logic             SW_RESET,
	output logic             FRAME_HEADER_DONE_FLAG,
	// Audio format override
	input  wire logic        AUD_SW_EN,
	input  wire logic        AUD_SW_32,
	input  wire logic        AUD_SW_INV,
	input  wire logic        AUD_SW_DLY,
	// Audio samples and serial output
	input  wire logic [19:0] AUD_LEFT,
	input  wire logic [19:0] AUD_RIGHT,
	output logic             AUD_TAKE,
	output logic             SERIAL_AUDIO_OUT,
	output logic             AUDIO_BIT_CLK,
	output logic             OUTPUT_WORD_STROBE
);
	typedef enum {ST_HOLD, ST_SAMPLE, ST_RUN} ssc_boot_t;
	ssc_boot_t   st_q;
	logic [15:0] cfg_q, stage_q;
	logic        expect_q, apply, rd_cmd, port_live;
	logic [19:0] stat;
	logic [7:0]  div_q;
	logic [5:0]  slot_q, slot_last;
	logic [4:0]  h, p;
	logic        tick, adv, half, valid, abit;
	logic        w32_q, inv_q, dly_q, w32_d;
	logic [19:0] sl_q, sr_q, smp;
	ssc_i2c_if   cbus ();

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// Serial control slave; pins only ever pull low
	ssc_i2c_slave u_i2c (
		.clk    (REF_CLK),
		.rst_n  (RST_N),
		.scl_i  (SCL_I),
		.sda_i  (SDA_I),
		.scl_oe (SCL_OE),
		.sda_oe (SDA_OE),
		.bus    (cbus.slave)
	);
	assign cbus.busy = (st_q != ST_RUN);
	assign cbus.rd_word = {5'h00, stat[19:17], stat[13:12], stat[8],
		stat[4:0]};

	// Open-drain data levels
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SCL_O <= 1'b0;
			SDA_O <= 1'b0;
		end else begin
			SCL_O <= 1'b0;
			SDA_O <= 1'b0;
		end
	end

	// Start-up sequence, restarted by reset or software reset
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			st_q <= ST_HOLD;
		else if (SW_RESET)
			st_q <= ST_HOLD;
		else begin
			unique case (st_q)
				ST_HOLD: st_q <= ST_SAMPLE;
				ST_SAMPLE: st_q <= ST_RUN;
				ST_RUN: st_q <= ST_RUN;
			endcase
		end
	end

	// Command words: staged configuration and the run trigger
	assign apply = cbus.wr_stb && !expect_q && cbus.wr_word ==
		ssc_pkg::RUN_CFG_ADDR;
	assign rd_cmd = cbus.wr_stb && !expect_q && cbus.wr_word[15:12] ==
		ssc_pkg::CMD_READ_CID;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			expect_q <= 1'b0;
			stage_q <= ssc_pkg::CFG_RESET;
		end else if (cbus.wr_stb) begin
			if (expect_q)
				stage_q <= cbus.wr_word;
			expect_q <= !expect_q && cbus.wr_word[15:12] ==
				ssc_pkg::CMD_WRITE_REG;
		end
	end

	// Boot configuration register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			cfg_q <= ssc_pkg::CFG_RESET;
		else if (st_q == ST_SAMPLE)
			cfg_q <= PORT_I[15:0] & ssc_pkg::CFG_MASK;
		else if (st_q == ST_RUN && apply)
			cfg_q <= stage_q & ssc_pkg::CFG_MASK;
	end

	// Strap decode onto configuration outputs
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CFG_CLK_HI <= 1'b0;
			CFG_LAYER3_EN <= 1'b0;
			CFG_LAYER2_EN <= 1'b0;
			CFG_OUT_32 <= 1'b0;
			CFG_PLL_ON <= 1'b0;
			CFG_CLOCK_OUTPUT_FIXED <= 1'b0;
		end else begin
			CFG_CLK_HI <= cfg_q[ssc_pkg::STRAP_CLK];
			CFG_LAYER3_EN <= !cfg_q[ssc_pkg::STRAP_L3];
			CFG_LAYER2_EN <= !cfg_q[ssc_pkg::STRAP_L2];
			CFG_OUT_32 <= !cfg_q[ssc_pkg::STRAP_W16];
			CFG_PLL_ON <= cfg_q[ssc_pkg::STRAP_PLL];
			CFG_CLOCK_OUTPUT_FIXED <= cfg_q[ssc_pkg::STRAP_CLOCK_OUTPUT];
		end
	end

	// Decoding permitted only for enabled layers 2 and 3
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			DECODE_EN <= 1'b0;
		else
			DECODE_EN <= (st_q == ST_RUN) &&
				((DEC_LAYER == ssc_pkg::LAYER_3 && CFG_LAYER3_EN) ||
				(DEC_LAYER == ssc_pkg::LAYER_2 && CFG_LAYER2_EN));
	end

	// Control register: one-shot software reset and task select
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SW_RESET <= 1'b0;
			TASK_SEL <= 4'h0;
		end else begin
			SW_RESET <= cbus.ctrl_stb && cbus.wr_word[ssc_pkg::CTRL_RESET_BIT];
			if (cbus.ctrl_stb)
				TASK_SEL <= cbus.wr_word[ssc_pkg::CTRL_TASK_LSB+:4];
		end
	end

	// Frame flag; a new header wins over a same-cycle clear
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			FRAME_HEADER_DONE_FLAG <= 1'b0;
		else if (DEC_HDR_DONE)
			FRAME_HEADER_DONE_FLAG <= 1'b1;
		else if (rd_cmd)
			FRAME_HEADER_DONE_FLAG <= 1'b0;
	end

	// Status word as shown on the port lines
	always_comb begin
		stat = 20'h0_0000;
		stat[ssc_pkg::LN_DEMAND] = DEC_DEMAND;
		stat[ssc_pkg::LN_IDX+:2] = DEC_MPEG_IDX;
		stat[ssc_pkg::LN_LAYER+:2] = DEC_LAYER;
		stat[ssc_pkg::LN_CRC] = DEC_CRC_ERR;
		stat[ssc_pkg::LN_SYNC] = FRAME_HEADER_DONE_FLAG;
		stat[ssc_pkg::LN_SRATE+:2] = DEC_SRATE;
		stat[ssc_pkg::LN_DEEMPH+:2] = DEC_DEEMPH;
	end

	// Port drive: inputs until sampled, then status outputs
	assign port_live = (st_q == ST_RUN) && PORT_REQUEST_LINE &&
		!PORT_SELECT_LINE;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PORT_OE <= 20'h0_0000;
			PORT_O <= 20'h0_0000;
		end else begin
			PORT_OE <= (st_q == ST_RUN) ? ssc_pkg::PORT_USED_MASK :
				20'h0_0000;
			if (port_live)
				PORT_O <= stat & ssc_pkg::PORT_USED_MASK;
		end
	end

	// Bit clock divider; each tick is half a bit period
	assign tick = (div_q == 8'(BCLK_DIV - 1));
	assign adv = tick && AUDIO_BIT_CLK;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			div_q <= 8'h00;
			AUDIO_BIT_CLK <= 1'b0;
		end else begin
			div_q <= tick ? 8'h00 : div_q + 8'd1;
			if (tick)
				AUDIO_BIT_CLK <= !AUDIO_BIT_CLK;
		end
	end

	// Slot position, channel half and data bit selection
	assign w32_d = AUD_SW_EN ? AUD_SW_32 : CFG_OUT_32;
	assign slot_last = w32_q ? 6'(2 * ssc_pkg::AUD_SLOT_32 - 1) :
		6'(ssc_pkg::AUD_SLOT_32 - 1);
	always_comb begin
		half = w32_q ? slot_q[5] : slot_q[4];
		h = w32_q ? slot_q[4:0] : {1'b0, slot_q[3:0]};
		p = h - {4'h0, dly_q};
		valid = (!dly_q || h != 5'd0) && (p < (w32_q ?
			5'(ssc_pkg::AUD_VALID_32) : 5'(ssc_pkg::AUD_VALID_16)));
		smp = half ? sr_q : sl_q;
		abit = valid ? smp[5'(ssc_pkg::AUD_BITS - 1) - p] : 1'b0;
	end

	// Serial audio shifter; format is taken once per stereo frame
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			slot_q <= 6'h00;
			w32_q <= 1'b0;
			inv_q <= 1'b0;
			dly_q <= 1'b1;
			sl_q <= 20'h0_0000;
			sr_q <= 20'h0_0000;
			AUD_TAKE <= 1'b0;
			SERIAL_AUDIO_OUT <= 1'b0;
			OUTPUT_WORD_STROBE <= 1'b0;
		end else begin
			AUD_TAKE <= 1'b0;
			if (adv) begin
				SERIAL_AUDIO_OUT <= abit;
				OUTPUT_WORD_STROBE <= half ^ inv_q;
				slot_q <= (slot_q == slot_last) ? 6'h00 : slot_q + 6'd1;
				if (slot_q == slot_last) begin
					sl_q <= AUD_LEFT;
					sr_q <= AUD_RIGHT;
					AUD_TAKE <= 1'b1;
					w32_q <= w32_d;
					inv_q <= AUD_SW_EN ? AUD_SW_INV : w32_d;
					dly_q <= AUD_SW_EN ? AUD_SW_DLY : !w32_d;
				end
			end
		end
	end

	// Checks
	a_strap_latch: assert property (
		(st_q == ST_SAMPLE && !SW_RESET) |=>
		cfg_q == ($past(PORT_I[15:0]) & 16'h011F))
		else $error("strap levels not latched");
	a_port_drive: assert property (
		(st_q == ST_RUN) |=> PORT_OE == 20'hF_F11F)
		else $error("port lines not driven after sampling");
	a_sw_reload: assert property (
		SW_RESET |=> st_q == ST_HOLD ##1
		st_q == ST_SAMPLE ##1 cfg_q == ($past(PORT_I[15:0]) & 16'h011F))
		else $error("software reset did not reload straps");
	a_demand_line: assert property (
		port_live |=> PORT_O[19] == $past(DEC_DEMAND) &&
		PORT_O[8] == $past(DEC_CRC_ERR))
		else $error("status lines wrong");
	a_layer1_skip: assert property (
		(DEC_LAYER == 2'h3) |=> !DECODE_EN)
		else $error("layer 1 decode enabled");
	a_frame_set: assert property (
		DEC_HDR_DONE |=>
		FRAME_HEADER_DONE_FLAG [*1] ##1 (FRAME_HEADER_DONE_FLAG ||
		$past(rd_cmd)))
		else $error("frame flag not set");
	a_frame_clear: assert property (
		(rd_cmd && !DEC_HDR_DONE) |=> !FRAME_HEADER_DONE_FLAG)
		else $error("frame flag not cleared by read command");
	a_trail_zero: assert property (
		(adv && w32_q && h > 5'd20) |=> !SERIAL_AUDIO_OUT)
		else $error("trailing audio slot not zero");
	a_strobe_half: assert property (
		(adv && w32_q && !inv_q) |=>
		OUTPUT_WORD_STROBE == $past(slot_q[5]))
		else $error("word strobe out of step");
	c_run_cfg: cover property (st_q == ST_RUN && apply);
	c_frame_read: cover property (FRAME_HEADER_DONE_FLAG ##[1:50] rd_cmd);
	c_take_32: cover property (AUD_TAKE && w32_q);
	c_sw_reset: cover property (SW_RESET);
endmodule : ssc_port

// *** tb/ssc_ctrl_model.sv ***
// System controller model: serial control bus master and port control.
// Assumes open-drain bus lines, resolved here from both parties' enables.
`timescale 1ns/100ps
module ssc_ctrl_model (
	// Clock
	input  wire logic clk,
	// Device pin drives
	input  wire logic scl_oe_dev,
	input  wire logic sda_oe_dev,
	// Resolved bus lines and port control
	output logic      scl,
	output logic      sda,
	output logic      req,
	output logic      sel
);
	logic mc = 1'b0;
	logic md = 1'b0;
	// Wired-and bus with pull-ups
	assign scl = ~(mc | scl_oe_dev);
	assign sda = ~(md | sda_oe_dev);
	// Request high, select low for status mode
	assign req = 1'b1;
	assign sel = 1'b0;
	task automatic hold();
		repeat (8) @(posedge clk);
	endtask : hold
	// Release clock and wait out any stretching
	task automatic sclhi();
		int n;
		mc <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (scl !== 1'b1 && n < 4000);
		hold();
	endtask : sclhi
	// Start, also used as repeated start
	task automatic start();
		md <= 1'b0;
		hold();
		sclhi();
		md <= 1'b1;
		hold();
		mc <= 1'b1;
		hold();
	endtask : start
	task automatic stop();
		md <= 1'b1;
		hold();
		sclhi();
		md <= 1'b0;
		hold();
	endtask : stop
	task automatic bitx(input logic b, output logic r);
		md <= ~b;
		hold();
		sclhi();
		r = sda;
		mc <= 1'b1;
		hold();
	endtask : bitx
	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(a, r);
	endtask : xfer
	// Word write: address, subaddress, high then low byte
	task automatic wr(input logic [7:0] dev, input logic [7:0] sub,
		input logic [15:0] w, output logic [3:0] ack);
		logic [7:0] q;
		logic       r;
		start();
		xfer(dev, 1'b1, q, r);
		ack[3] = ~r;
		xfer(sub, 1'b1, q, r);
		ack[2] = ~r;
		xfer(w[15:8], 1'b1, q, r);
		ack[1] = ~r;
		xfer(w[7:0], 1'b1, q, r);
		ack[0] = ~r;
		stop();
	endtask : wr
	// Word read through subaddress write and repeated start
	task automatic rd(output logic [15:0] w);
		logic r;
		start();
		xfer(8'h3A, 1'b1, w[7:0], r);
		xfer(8'h69, 1'b1, w[7:0], r);
		start();
		xfer(8'h3B, 1'b1, w[7:0], r);
		xfer(8'hFF, 1'b0, w[15:8], r);
		xfer(8'hFF, 1'b1, w[7:0], r);
		stop();
	endtask : rd
endmodule : ssc_ctrl_model

// *** tb/ssc_port_tb.sv ***
// Self-checking bench of the strap, status and control port.
// Assumes the controller model drives the bus; straps via resistors.
`timescale 1ns/100ps
module ssc_port_tb;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [19:0] strap = 20'h0_0000;
	logic [19:0] port_o, port_oe, pin;
	logic        scl, sda, scl_oe, sda_oe, req, sel, decen, flag;
	logic        dem = 1'b0, crc = 1'b0, hdr = 1'b0;
	logic        take, serial_audio_out, bck, ws;
	logic [1:0]  idx = 2'h0, lay = 2'h0, sr = 2'h0, de = 2'h0;
	logic [19:0] aud = 20'hA_5C31;
	logic [5:0]  cfg;
	logic [3:0]  tsel, ack;
	logic [15:0] w;
	int          err_count = 0, compares = 0, cyc = 0;
	always #4 ref_clk = ~ref_clk;
	// Pin level: device drive where enabled, else strap resistor
	assign pin = (port_oe & port_o) | (~port_oe & strap);
	ssc_ctrl_model ctl (.clk(ref_clk), .scl_oe_dev(scl_oe),
		.sda_oe_dev(sda_oe), .scl(scl), .sda(sda), .req(req), .sel(sel));
	ssc_port uut (.REF_CLK(ref_clk), .RST_N(rst_n), .PORT_I(pin),
		.PORT_O(port_o), .PORT_OE(port_oe), .PORT_REQUEST_LINE(req),
		.PORT_SELECT_LINE(sel), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe),
		.SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .DEC_DEMAND(dem),
		.DEC_MPEG_IDX(idx), .DEC_LAYER(lay), .DEC_CRC_ERR(crc),
		.DEC_HDR_DONE(hdr), .DEC_SRATE(sr), .DEC_DEEMPH(de),
		.CFG_CLK_HI(cfg[5]), .CFG_LAYER3_EN(cfg[4]),
		.CFG_LAYER2_EN(cfg[3]), .CFG_OUT_32(cfg[2]), .CFG_PLL_ON(cfg[1]),
		.CFG_CLOCK_OUTPUT_FIXED(cfg[0]), .DECODE_EN(decen), .TASK_SEL(tsel),
		.SW_RESET(), .FRAME_HEADER_DONE_FLAG(flag), .AUD_SW_EN(1'b0),
		.AUD_SW_32(1'b0), .AUD_SW_INV(1'b0), .AUD_SW_DLY(1'b0),
		.AUD_LEFT(aud), .AUD_RIGHT(~aud), .AUD_TAKE(take),
		.SERIAL_AUDIO_OUT(serial_audio_out), .AUDIO_BIT_CLK(bck),
		.OUTPUT_WORD_STROBE(ws));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("compares=%0d errors=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic do_reset(input logic [19:0] s);
		strap <= s;
		rst_n <= 1'b0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask : do_reset
	// Strap decode and output switch-over after reset
	task automatic t_strap(input logic [5:0] exp);
		chk(cfg, exp);
		chk(port_oe, 20'hF_F11F);
	endtask : t_strap
	// One whole audio frame after a sample take, sampled at bit clock rise
	task automatic t_audio(input int n, input logic [63:0] ed,
		input logic [63:0] es);
		logic [63:0] d, s;
		d = 64'h0000_0000_0000_0000;
		s = 64'h0000_0000_0000_0000;
		while (take !== 1'b1)
			@(posedge ref_clk);
		@(posedge bck);
		repeat (n) begin
			@(posedge bck);
			d = {d[62:0], serial_audio_out};
			s = {s[62:0], ws};
		end
		chk(d[63:32], ed[63:32]);
		chk(d[31:0], ed[31:0]);
		chk(s[63:32], es[63:32]);
		chk(s[31:0], es[31:0]);
	endtask : t_audio
	// Status lines, bus readback and layer gating
	task automatic t_status();
		dem <= 1'b1;
		idx <= 2'h2;
		lay <= 2'h1;
		crc <= 1'b1;
		sr <= 2'h1;
		de <= 2'h3;
		repeat (3) @(posedge ref_clk);
		chk(port_o, 20'hC_1107);
		chk(decen, 1'b1);
		ctl.rd(w);
		chk(w, 16'h0667);
		lay <= 2'h3;
		repeat (3) @(posedge ref_clk);
		chk({decen, port_o[13:12]}, 3'h3);
		lay <= 2'h2;
		repeat (3) @(posedge ref_clk);
		chk(decen, 1'b0);
	endtask : t_status
	// Frame flag set by header done, cleared by read command
	task automatic t_flag();
		hdr <= 1'b1;
		@(posedge ref_clk);
		hdr <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({flag, port_o[4]}, 2'h3);
		ctl.wr(8'h3A, 8'h68, 16'h3000, ack);
		repeat (2) @(posedge ref_clk);
		chk({flag, ack}, 5'h0F);
	endtask : t_flag
	// Staged boot configuration applied by run at $fcd
	task automatic t_load();
		ctl.wr(8'h3A, 8'h68, 16'h9000, ack);
		ctl.wr(8'h3A, 8'h68, 16'h0106, ack);
		ctl.wr(8'h3A, 8'h68, 16'h0FCD, ack);
		repeat (3) @(posedge ref_clk);
		chk(cfg, 6'b010001);
		do_reset(20'h0_0006);
		chk(cfg, 6'b010000);
	endtask : t_load
	// Foreign address and subaddress refused, control word taken
	task automatic t_refuse();
		ctl.wr(8'h3C, 8'h68, 16'h0000, ack);
		chk(ack, 4'h0);
		ctl.wr(8'h3A, 8'h6B, 16'h0000, ack);
		chk(ack, 4'h8);
		ctl.wr(8'h3A, 8'h6A, 16'h000F, ack);
		repeat (2) @(posedge ref_clk);
		chk({tsel, ack}, 8'hFF);
		strap <= 20'h0_0119;
		ctl.wr(8'h3A, 8'h6A, 16'h0100, ack);
		repeat (5) @(posedge ref_clk);
		chk({cfg, tsel, ack}, 14'b101111_0000_1111);
	endtask : t_refuse
	// Cut a hang short
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		do_reset(20'h0_0119);
		t_strap(6'b101111);
		t_audio(64, 64'hA5C3_1000_5A3C_E000,
			64'hFFFF_FFFF_0000_0000);
		do_reset(20'h0_0006);
		t_strap(6'b010000);
		t_audio(32, 64'h0000_0000_52E1_2D1E,
			64'h0000_0000_0000_FFFF);
		t_status();
		t_flag();
		t_load();
		t_refuse();
		end_of_test();
	end
endmodule : ssc_port_tb
